// file: src/esr_consts.vh
// Constants for the embedded synchronous RAM block: APB map, fields, modes, sizes.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef ESR_CONSTS_VH
`define ESR_CONSTS_VH

// ==========================================
// Register map (byte addresses)
`define ESR_ADDR_W 12
`define ESR_CTRL_OFF 12'h000
`define ESR_STAT_OFF 12'h004

// ==========================================
// Control fields
`define ESR_MODE_LSB 0
`define ESR_MODE_MSB 1
`define ESR_OREG_A_BIT 2
`define ESR_OREG_B_BIT 3
`define ESR_FLOW_BIT 4
`define ESR_CTRL_MASK 32'h0000001f
`define ESR_CTRL_RST 32'h00000000

// ==========================================
// Status fields, write one to clear
`define ESR_COLL_BIT 0
`define ESR_DROP_BIT 1

// ==========================================
// Operating modes
`define ESR_MODE_TDP 2'h0
`define ESR_MODE_SDP 2'h1
`define ESR_MODE_SP 2'h2
`define ESR_MODE_SPLIT 2'h3

// ==========================================
// Physical sizes in bits, parity positions included
`define ESR_SMALL_BITS 576
`define ESR_MED_BITS 4608
`define ESR_LARGE_BITS 589824
`define ESR_BYTE_W 9

`endif

// file: src/esr_ram_block.v
// Embedded synchronous RAM block with two ports, mixed widths and APB control.
// Assumes user logic on pclk drives the ports; clears may arrive at any time.
//
// Design decisions made here: the APB register port and the register offsets.
`include "esr_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module esr_ram_block #(
    parameter TOTAL_BITS = `ESR_MED_BITS,
    parameter WA = 36,
    parameter WB = 36,
    parameter AWA = 7,
    parameter AWB = 7
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire [`ESR_ADDR_W-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Clock enables and asynchronous clears
    input wire in_clken,
    input wire out_clken,
    input wire in_aclr,
    input wire out_aclr,
    // Port A
    input wire [AWA-1:0] a_addr,
    input wire [WA-1:0] a_wdata,
    input wire a_we,
    input wire a_re,
    output reg [WA-1:0] a_rdata,
    // Port B
    input wire [AWB-1:0] b_addr,
    input wire [WB-1:0] b_wdata,
    input wire b_we,
    input wire b_re,
    output reg [WB-1:0] b_rdata
);

localparam HALF = TOTAL_BITS / 2;

// ==========================================
// Storage, one bit per entry so ports of any width share it
// Trade-off: bit-wide entries cost simulation speed but allow free widths
reg mem [0:TOTAL_BITS-1];

// ==========================================
// Control and status
reg [31:0] ctrl;
reg coll;
reg drop;
wire [1:0] mode = ctrl[`ESR_MODE_MSB:`ESR_MODE_LSB];
wire oreg_a = ctrl[`ESR_OREG_A_BIT];
wire oreg_b = ctrl[`ESR_OREG_B_BIT];
wire ft = ctrl[`ESR_FLOW_BIT] & (mode == `ESR_MODE_SDP);
wire split = (mode == `ESR_MODE_SPLIT);
wire wt = (mode == `ESR_MODE_SP) | split;

// ==========================================
// Input registers
reg [AWA-1:0] a_addr_r;
reg [WA-1:0] a_wdata_r;
reg a_we_r;
reg a_re_r;
reg [AWB-1:0] b_addr_r;
reg [WB-1:0] b_wdata_r;
reg b_we_r;
reg b_re_r;
reg [AWB-1:0] b_addr_n;
reg b_re_n;

// Clear acts without a clock; reset and clear leave the same state
always @(posedge pclk or negedge presetn or posedge in_aclr) begin
    if (!presetn) begin
        a_addr_r <= {AWA{1'b0}};
        a_wdata_r <= {WA{1'b0}};
        a_we_r <= 1'b0;
        a_re_r <= 1'b0;
        b_addr_r <= {AWB{1'b0}};
        b_wdata_r <= {WB{1'b0}};
        b_we_r <= 1'b0;
        b_re_r <= 1'b0;
    end else if (in_aclr) begin
        a_addr_r <= {AWA{1'b0}};
        a_wdata_r <= {WA{1'b0}};
        a_we_r <= 1'b0;
        a_re_r <= 1'b0;
        b_addr_r <= {AWB{1'b0}};
        b_wdata_r <= {WB{1'b0}};
        b_we_r <= 1'b0;
        b_re_r <= 1'b0;
    end else if (in_clken) begin
        a_addr_r <= a_addr;
        a_wdata_r <= a_wdata;
        a_we_r <= a_we;
        a_re_r <= a_re;
        b_addr_r <= b_addr;
        b_wdata_r <= b_wdata;
        b_we_r <= b_we;
        b_re_r <= b_re;
    end
end

// Falling-edge read capture halves read latency in flow-through use
// Clock enable gates this stage too, so a stalled pipe stays coherent
always @(negedge pclk or negedge presetn or posedge in_aclr) begin
    if (!presetn) begin
        b_addr_n <= {AWB{1'b0}};
        b_re_n <= 1'b0;
    end else if (in_aclr) begin
        b_addr_n <= {AWB{1'b0}};
        b_re_n <= 1'b0;
    end else if (in_clken) begin
        b_addr_n <= b_addr;
        b_re_n <= b_re;
    end
end

// ==========================================
// Port qualification and addressing
wire wa_en = a_we_r & (mode != `ESR_MODE_SDP | 1'b1);
wire ra_en = a_re_r & (mode != `ESR_MODE_SDP);
wire wb_en = b_we_r & ((mode == `ESR_MODE_TDP) | split);
wire rb_sel = ft ? b_re_n : b_re_r;
wire rb_en = rb_sel & (mode != `ESR_MODE_SP);
wire [AWB-1:0] b_addr_e = ft ? b_addr_n : b_addr_r;

integer a_base;
integer b_base;
reg a_ok;
reg b_ok;
reg overlap;

always @* begin
    a_base = a_addr_r * WA;
    b_base = b_addr_e * WB;
    if (split) begin
        // Each port owns one half; an address past it is refused, not wrapped
        b_base = b_base + HALF;
        a_ok = (a_base + WA) <= HALF;
        b_ok = (b_base + WB) <= TOTAL_BITS;
    end else begin
        a_ok = (a_base + WA) <= TOTAL_BITS;
        b_ok = (b_base + WB) <= TOTAL_BITS;
    end
    overlap = (a_base < b_base + WB) && (b_base < a_base + WA);
end

// Combinational array read; sampled by the output stage below
reg [WA-1:0] a_rd;
reg [WB-1:0] b_rd;
integer i;
integer j;

always @* begin
    a_rd = {WA{1'b0}};
    b_rd = {WB{1'b0}};
    for (i = 0; i < WA; i = i + 1) begin
        if (a_ok) begin
            a_rd[i] = mem[a_base + i];
        end
    end
    for (j = 0; j < WB; j = j + 1) begin
        if (b_ok) begin
            b_rd[j] = mem[b_base + j];
        end
    end
end

// ==========================================
// Array write from registered inputs; port A wins a double write
// No reset on the array: contents stay unknown until written
integer k;

always @(posedge pclk) begin
    for (k = 0; k < WB; k = k + 1) begin
        if (wb_en && b_ok) begin
            mem[b_base + k] <= b_wdata_r[k];
        end
    end
    for (k = 0; k < WA; k = k + 1) begin
        if (wa_en && a_ok) begin
            mem[a_base + k] <= a_wdata_r[k];
        end
    end
end

// ==========================================
// Output stages
wire [WA-1:0] a_src = (wt & wa_en) ? a_wdata_r : a_rd;
wire a_src_v = ra_en | (wt & wa_en);
wire [WB-1:0] b_src = (split & wb_en) ? b_wdata_r : b_rd;
wire b_src_v = rb_en | (split & wb_en);
reg [WA-1:0] a_pipe;
reg a_pipe_v;
reg [WB-1:0] b_pipe;
// Valid bit travels with the pipe so stale data is never shown
reg b_pipe_v;

always @(posedge pclk or negedge presetn or posedge out_aclr) begin
    if (!presetn) begin
        a_pipe <= {WA{1'b0}};
        a_pipe_v <= 1'b0;
        a_rdata <= {WA{1'b0}};
        b_pipe <= {WB{1'b0}};
        b_pipe_v <= 1'b0;
        b_rdata <= {WB{1'b0}};
    end else if (out_aclr) begin
        a_pipe <= {WA{1'b0}};
        a_pipe_v <= 1'b0;
        a_rdata <= {WA{1'b0}};
        b_pipe <= {WB{1'b0}};
        b_pipe_v <= 1'b0;
        b_rdata <= {WB{1'b0}};
    end else if (out_clken) begin
        if (oreg_a) begin
            a_pipe <= a_src;
            a_pipe_v <= a_src_v;
            if (a_pipe_v) begin
                a_rdata <= a_pipe;
            end
        end else if (a_src_v) begin
            a_rdata <= a_src;
        end
        if (oreg_b) begin
            b_pipe <= b_src;
            b_pipe_v <= b_src_v;
            if (b_pipe_v) begin
                b_rdata <= b_pipe;
            end
        end else if (b_src_v) begin
            b_rdata <= b_src;
        end
    end
end

// ==========================================
// APB slave: no wait states, pready from a flop
// Unmapped offsets answer with an error and are never written
wire setup = psel & ~penable & ~pready;
wire hit_ctrl = (paddr == `ESR_CTRL_OFF);
wire hit_stat = (paddr == `ESR_STAT_OFF);
wire wr_now = psel & penable & pready & pwrite;
wire coll_set = overlap & a_ok & b_ok & ((wa_en & rb_en) | (wb_en & ra_en) | (wa_en & wb_en));
wire drop_set = (b_we_r & ~wb_en) | (rb_sel & (mode == `ESR_MODE_SP));
wire stat_clr = wr_now & hit_stat;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl <= `ESR_CTRL_RST;
        coll <= 1'b0;
        drop <= 1'b0;
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= setup;
        if (setup) begin
            pslverr <= ~(hit_ctrl | hit_stat);
            if (pwrite | ~(hit_ctrl | hit_stat)) begin
                prdata <= 32'h00000000;
            end else if (hit_ctrl) begin
                prdata <= ctrl;
            end else begin
                prdata <= {30'h00000000, drop, coll};
            end
        end else begin
            pslverr <= 1'b0;
        end
        if (wr_now && hit_ctrl) begin
            ctrl <= pwdata & `ESR_CTRL_MASK;
        end
        // New events win over a clear in the same cycle
        coll <= coll_set | (coll & ~(stat_clr & pwdata[`ESR_COLL_BIT]));
        drop <= drop_set | (drop & ~(stat_clr & pwdata[`ESR_DROP_BIT]));
    end
end

endmodule // esr_ram_block

`default_nettype wire

// file: tb/esr_ram_block_chk.sv
// Checker for the RAM block: APB answer timing, clears, read data holding.
// Sees only the block's ports; bound from the bench top.
`timescale 1ns/1ps
`default_nettype none
module esr_ram_block_chk #(parameter WA = 36, parameter WB = 36) (
    // Clock, reset, APB
    input wire logic pclk, input wire logic presetn, input wire logic [11:0] paddr,
    input wire logic psel, input wire logic penable, input wire logic pready,
    input wire logic pslverr,
    // RAM controls and outputs
    input wire logic in_clken, input wire logic in_aclr, input wire logic out_aclr,
    input wire logic a_we, input wire logic a_re,
    input wire logic [WA-1:0] a_rdata, input wire logic [WB-1:0] b_rdata
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // APB answer
    property p_ans; psel && !penable |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer after setup");
    property p_src; pready |-> $past(psel && !penable); endproperty
    a_src: assert property (p_src) else $error("answer without setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("answer longer than one cycle");
    property p_err; psel && !penable && paddr[11:3] != 9'h0 |=> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped address not refused");
    // ==========
    // Read data
    property p_oclr; out_aclr |-> a_rdata == '0 && b_rdata == '0; endproperty
    a_oclr: assert property (p_oclr) else $error("output clear ignored");
    property p_iclr; disable iff (!presetn || out_aclr)
        in_aclr [*2] |=> $stable(a_rdata) && $stable(b_rdata); endproperty
    a_iclr: assert property (p_iclr) else $error("data moved under input clear");
    property p_hold; disable iff (!presetn || out_aclr)
        (!a_re && !a_we && in_clken && !in_aclr) [*3] |=> $stable(a_rdata); endproperty
    a_hold: assert property (p_hold) else $error("data moved without read");
    property p_clken; disable iff (!presetn || out_aclr)
        (!in_clken && !in_aclr) [*3] |=> $stable(a_rdata) && $stable(b_rdata); endproperty
    a_clken: assert property (p_clken) else $error("data moved while disabled");
    c_err: cover property (pready && pslverr);
    c_oclr: cover property (out_aclr);
    c_clken: cover property (!in_clken [*3]);
endmodule // esr_ram_block_chk
`default_nettype wire

// file: tb/esr_ram_block_tb.sv
// Bench for the RAM block: APB control, port traffic through the user model.
// Assumes the default 36-bit ports of a 128-word block.
`timescale 1ns/1ps
`default_nettype none
module esr_ram_block_tb;
    logic pclk, presetn, psel, penable, pwrite, in_clken, out_clken, in_aclr, out_aclr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, e, a_we, a_re, b_we, b_re;
    logic [6:0] a_addr, b_addr;
    logic [35:0] a_wdata, b_wdata, a_rdata, b_rdata;
    integer n_errors = 0;
    integer total_checks = 0;
    localparam logic [35:0] D1 = 36'h804020100;
    localparam logic [35:0] D2 = 36'h7fbfdfeff;
    localparam logic [35:0] D3 = 36'h123456789;
    esr_ram_block u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .in_clken, .out_clken, .in_aclr, .out_aclr, .a_addr, .a_wdata,
        .a_we, .a_re, .a_rdata, .b_addr, .b_wdata, .b_we, .b_re, .b_rdata);
    esr_user_model u_usr (.pclk, .a_addr, .a_wdata, .a_we, .a_re, .b_addr, .b_wdata,
        .b_we, .b_re);
    // ==========
    // Tasks
    task chk(input string nm, input logic [35:0] s, input logic [35:0] x);
        total_checks++;
        if (s !== x) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask
    task test_done;
        if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task wt;
        @(posedge pclk);
        #1;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        if (i == 8) begin
            n_errors++;
            test_done;
        end
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    // ==========
    // Sequence
    initial begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        {psel, penable, pwrite, in_aclr, out_aclr, presetn, paddr, pwdata} = '0;
        {in_clken, out_clken} = 2'h3;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h1, 12'h000, 32'hffffffff);
        apb(1'h0, 12'h000, 32'h0);
        chk("ctrl", q, 36'h1f);
        apb(1'h0, 12'h008, 32'h0);
        chk("pslverr", e, 36'h1);
        apb(1'h1, 12'h000, 32'h0);
        u_usr.op(2'h2, 7'h05, D1, 2'h2, 7'h09, D2);
        u_usr.op(2'h1, 7'h09, D3, 2'h1, 7'h05, D3);
        wt;
        chk("a_rdata", a_rdata, D2);
        chk("b_rdata", b_rdata, D1);
        @(posedge pclk);
        in_clken <= 1'h0;
        u_usr.op(2'h2, 7'h09, D3, 2'h0, 7'h00, D3);
        @(posedge pclk);
        in_clken <= 1'h1;
        u_usr.op(2'h1, 7'h09, D3, 2'h0, 7'h00, D3);
        repeat (3) wt;
        chk("a_rdata", a_rdata, D2);
        apb(1'h1, 12'h000, 32'h4);
        u_usr.op(2'h1, 7'h05, D3, 2'h0, 7'h00, D3);
        wt;
        chk("a_rdata", a_rdata, D2);
        wt;
        chk("a_rdata", a_rdata, D1);
        apb(1'h1, 12'h000, 32'h1);
        u_usr.op(2'h2, 7'h05, D3, 2'h1, 7'h05, D3);
        wt;
        chk("b_rdata", b_rdata, D1);
        u_usr.op(2'h0, 7'h00, D3, 2'h2, 7'h09, D1);
        apb(1'h0, 12'h004, 32'h0);
        chk("stat", q, 36'h3);
        apb(1'h1, 12'h004, 32'h3);
        apb(1'h1, 12'h000, 32'h11);
        u_usr.op(2'h0, 7'h00, D3, 2'h1, 7'h09, D3);
        #1;
        chk("b_rdata", b_rdata, D2);
        apb(1'h1, 12'h000, 32'h2);
        u_usr.op(2'h2, 7'h03, D1, 2'h0, 7'h00, D3);
        wt;
        chk("a_rdata", a_rdata, D1);
        @(posedge pclk);
        in_aclr <= 1'h1;
        repeat (2) wt;
        chk("a_rdata", a_rdata, D1);
        @(posedge pclk);
        {in_aclr, out_aclr} <= 2'h1;
        #1;
        chk("a_rdata", a_rdata, 36'h0);
        @(posedge pclk);
        out_aclr <= 1'h0;
        apb(1'h1, 12'h000, 32'h3);
        u_usr.op(2'h2, 7'h03, D2, 2'h2, 7'h03, D3);
        u_usr.op(2'h1, 7'h03, D1, 2'h1, 7'h40, D1);
        wt;
        chk("a_rdata", a_rdata, D2);
        chk("b_rdata", b_rdata, 36'h0);
        test_done;
    end
endmodule // esr_ram_block_tb
bind esr_ram_block esr_ram_block_chk #(.WA(WA), .WB(WB)) u_chk (.pclk, .presetn, .paddr,
    .psel, .penable, .pready, .pslverr, .in_clken, .in_aclr, .out_aclr, .a_we, .a_re,
    .a_rdata, .b_rdata);
`default_nettype wire

// file: tb/esr_user_model.sv
// Fabric user logic facing both RAM ports.
// Drives just after rising pclk edges; the bench calls op().
`timescale 1ns/1ps
`default_nettype none
module esr_user_model (
    // Clock
    input wire logic pclk,
    // Port A and port B requests
    output logic [6:0] a_addr, output logic [35:0] a_wdata, output logic a_we, output logic a_re,
    output logic [6:0] b_addr, output logic [35:0] b_wdata, output logic b_we, output logic b_re
);
    initial {a_addr, a_wdata, a_we, a_re, b_addr, b_wdata, b_we, b_re} = '0;
    // Arguments wa, wb are {write, read}; request stands for one edge
    task op(input logic [1:0] wa, input logic [6:0] aa, input logic [35:0] da,
            input logic [1:0] wb, input logic [6:0] ba, input logic [35:0] db);
        @(posedge pclk);
        {a_we, a_re} <= wa;
        {b_we, b_re} <= wb;
        {a_addr, a_wdata, b_addr, b_wdata} <= {aa, da, ba, db};
        @(posedge pclk);
        {a_we, a_re, b_we, b_re} <= 4'h0;
        // Released data must not look like a held value
        {a_wdata, b_wdata} <= ~{da, db};
    endtask
endmodule // esr_user_model
`default_nettype wire
